// *** ctb_core.sv ***
//
// Contract
// - copy register or register pair, 1 cycle
// - immediate constant to register, 1 cycle
// - pointer load then pointer increment, 2 cycles
// - decrement pointer then load, 2 cycles
// - load from Y/Z plus displacement, 2 cycles
// - load from absolute address, 2 cycles; the core takes 3 or more, waiting for the address as a second bus word
// - pointer store then pointer increment, 2 cycles
// - decrement pointer then store, 2 cycles
// - store displaced or absolute, 2 cycles; absolute takes 3 or more here, as the address is a second bus word
// - program byte by Z to register, 3 cycles
// - write R1:R0 word to program memory
// - push and pop register, 2 cycles
// - set or clear one I/O bit
// - logical shifts update Z,C,N,V
// - rotates through carry update Z,C,N,V
// - arithmetic right shift keeps bit 7
// - swap nibbles, no flag change
// - set or clear indexed status bit
// - register bit to T, T to bit
// - single flag set and clear instructions
// - no operation; debug halt only for debugger
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ctb_defs.svh"
module ctb_core (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output ctb_pkg::ctb_mem_req_t dmem,
   input  wire logic [7:0]  dmem_rdata,
   output ctb_pkg::ctb_pgm_req_t pmem,
   input  wire logic [7:0]  pmem_rdata,
   input  wire logic        pmem_done,
   output logic             debug_halt
);
   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic        ap_wr;
   logic [31:0] ap_addr;
   logic        issue;
   logic [15:0] ir;
   logic [7:0]  status_register;
   logic [4:0]  regsel;
   logic [7:0]  rf [32];
   logic [15:0] sp;
   ctb_pkg::ctb_state_t state;
   logic        stall;
   logic [4:0]  pend_rd;
   logic [1:0]  pend_kind;
   logic        take_addr;
   assign stall = (state != ctb_pkg::CTB_ST_IDLE);
   // address word of an absolute access is taken while busy, never stalled
   assign take_addr = (state == ctb_pkg::CTB_ST_MEM) && (pend_kind == 2'b10);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr   <= 1'b0;
         ap_addr <= 32'h0000_0000;
      end else if (hready) begin
         ap_wr   <= hsel & htrans[1] & hwrite;
         ap_addr <= haddr;
      end
   end
   // writes of a new instruction wait while busy, so program order holds
   assign hreadyout = !(ap_wr && ap_addr == `CTB_ADDR_INSTR && stall && !take_addr);
   assign hresp = 1'b0;
   assign issue = ap_wr && ap_addr == `CTB_ADDR_INSTR && !stall;
   // ----------------------------------------
   // bus read data
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr)
            `CTB_ADDR_INSTR:  hrdata <= {16'h0000, ir};
            `CTB_ADDR_STATUS: hrdata <= {24'h000000, status_register};
            `CTB_ADDR_REGSEL: hrdata <= {27'h0000000, regsel};
            `CTB_ADDR_REGDAT: hrdata <= {24'h000000, rf[regsel]};
            `CTB_ADDR_PTRS:   hrdata <= {sp, rf[31], rf[30]};
            `CTB_ADDR_BUSY:   hrdata <= {31'h00000000, stall};
            default:          hrdata <= 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         regsel <= 5'h00;
      end else if (ap_wr && ap_addr == `CTB_ADDR_REGSEL) begin
         regsel <= hwdata[4:0];
      end
   end
   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic [15:0] pair(input logic [4:0] lo);
      pair = {rf[lo + 5'h01], rf[lo]};
   endfunction
   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction
   function automatic logic [15:0] io_addr(input logic [5:0] p);
      io_addr = {10'h000, p} + `CTB_IO_BASE;
   endfunction
   logic [15:0] w;
   logic [4:0]  rd;
   logic [4:0]  rr;
   logic [4:0]  rd_hi;
   logic [7:0]  kimm;
   logic [5:0]  q;
   logic [5:0]  pio;
   logic [4:0]  pidx;
   assign w     = hwdata[15:0];
   assign rd    = w[8:4];
   assign rr    = {w[9], w[3:0]};
   assign rd_hi = {1'b1, w[7:4]};
   assign kimm  = {w[11:8], w[3:0]};
   assign q     = {w[13], w[11:10], w[2:0]};
   assign pio   = {w[10:9], w[3:0]};
   // pointer pairs: X=r27:r26, Y=r29:r28, Z=r31:r30
   assign pidx  = (w[3:2] == 2'b11) ? 5'h1A : (w[3] ? 5'h1C : 5'h1E);
   // ----------------------------------------
   // pointers
   // ----------------------------------------
   logic [15:0] ptr;
   logic [15:0] ptr_dec;
   logic [15:0] ptr_inc;
   assign ptr     = pair(pidx);
   assign ptr_dec = ptr - 16'h0001;
   assign ptr_inc = ptr + 16'h0001;
   logic [7:0] src;
   assign src = rf[rd];
   // ----------------------------------------
   // instruction classes
   // ----------------------------------------
   logic        is_addrot;
   logic        is_shift;
   logic        is_io_in;
   logic        is_io_out;
   logic        is_iobit;
   logic        is_pgm_rd;
   logic        is_copy;
   logic        is_pair_copy;
   logic        is_nib_swap;
   logic        is_flag_bit;
   logic        is_stack;
   logic        is_abs_mem;
   logic        is_ptr_mem;
   logic        is_disp_mem;
   // shift up and carry rotate up reuse the add encodings with equal operands
   assign is_addrot    = (w[15:10] == 6'b000011 || w[15:10] == 6'b000111) && (rd == rr);
   assign is_shift     = (w[15:9] == 7'b1001010) && (w[3:0] == 4'h5 || w[3:1] == 3'b011);
   assign is_io_in     = (w[15:11] == 5'b10110);
   assign is_io_out    = (w[15:11] == 5'b10111);
   assign is_iobit     = (w[15:10] == 6'b100110) && !w[8];
   assign is_pgm_rd    = (w == 16'h95C8) || (w == 16'h95D8) || (w[15:9] == 7'b1001000 && w[3:1] == 3'b010);
   assign is_copy      = (w[15:10] == 6'b001011);
   assign is_pair_copy = (w[15:8] == 8'h01);
   assign is_nib_swap  = (w[15:9] == 7'b1001010) && (w[3:0] == 4'h2);
   assign is_flag_bit  = (w[15:8] == 8'h94) && (w[3:0] == 4'h8);
   assign is_stack     = (w[15:10] == 6'b100100) && (w[3:0] == 4'hF);
   assign is_abs_mem   = (w[15:10] == 6'b100100) && (w[3:0] == 4'h0);
   assign is_ptr_mem   = (w[15:10] == 6'b100100) && (w[3:0] != 4'h0) && (w[1:0] != 2'b11);
   assign is_disp_mem  = (w[15:14] == 2'b10) && (w[12] == 1'b0);
   // ----------------------------------------
   // shift unit
   // ----------------------------------------
   logic [7:0] sh;
   logic       shc;
   logic [7:0] next_status_register;
   always_comb begin
      sh  = src;
      shc = status_register[`CTB_STATUS_REGISTER_C];
      unique case (w[3:0])
         4'h6: begin
            sh  = {1'b0, src[7:1]};
            shc = src[0];
         end
         4'h7: begin
            sh  = {status_register[`CTB_STATUS_REGISTER_C], src[7:1]};
            shc = src[0];
         end
         4'h5: begin
            sh  = {src[7], src[7:1]};
            shc = src[0];
         end
         default: begin
            sh  = {src[6:0], 1'b0};
            shc = src[7];
         end
      endcase
      next_status_register = status_register;
      next_status_register[`CTB_STATUS_REGISTER_C] = shc;
      next_status_register[`CTB_STATUS_REGISTER_Z] = (sh == 8'h00);
      next_status_register[`CTB_STATUS_REGISTER_N] = sh[7];
      next_status_register[`CTB_STATUS_REGISTER_V] = sh[7] ^ shc;
      next_status_register[`CTB_STATUS_REGISTER_S] = sh[7] ^ (sh[7] ^ shc);
   end
   // ----------------------------------------
   // execute
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state      <= ctb_pkg::CTB_ST_IDLE;
         ir         <= 16'h0000;
         status_register       <= `CTB_STATUS_REGISTER_RESET;
         sp         <= `CTB_SP_RESET;
         dmem       <= '0;
         pmem       <= '0;
         pend_rd    <= 5'h00;
         pend_kind  <= 2'b00;
         debug_halt <= 1'b0;
         for (int i = 0; i < 32; i++) rf[i] <= 8'h00;
      end else begin
         dmem.req   <= 1'b0;
         debug_halt <= 1'b0;
         unique case (state)
            ctb_pkg::CTB_ST_IDLE: if (issue) begin
               ir <= w;
               if (is_copy) begin
                  rf[rd] <= rf[rr];
               end else if (is_pair_copy) begin
                  rf[{w[7:4], 1'b0}] <= rf[{w[3:0], 1'b0}];
                  rf[{w[7:4], 1'b1}] <= rf[{w[3:0], 1'b1}];
               end else if (w[15:12] == 4'hE) begin
                  rf[rd_hi] <= kimm;
               end else if (is_io_in) begin
                  // port data is only valid once the request is out, so input waits a cycle
                  dmem <= '{req: 1'b1, we: 1'b0, addr: io_addr(pio), wdata: 8'h00};
                  pend_rd <= rd;
                  pend_kind <= 2'b01;
                  state <= ctb_pkg::CTB_ST_MEM;
               end else if (is_io_out) begin
                  dmem <= '{req: 1'b1, we: 1'b1, addr: io_addr(pio), wdata: src};
               end else if (is_iobit) begin
                  // read-modify-write of one io bit needs a read first
                  dmem <= '{req: 1'b1, we: 1'b0, addr: io_addr({1'b0, w[7:3]}), wdata: 8'h00};
                  pend_kind <= 2'b11;
                  state <= ctb_pkg::CTB_ST_MEM;
               end else if (is_shift) begin
                  status_register <= next_status_register;
                  rf[rd] <= sh;
               end else if (is_addrot) begin
                  status_register[`CTB_STATUS_REGISTER_S] <= src[7];
                  rf[rd] <= {src[6:0], w[12] & status_register[`CTB_STATUS_REGISTER_C]};
                  status_register[`CTB_STATUS_REGISTER_C] <= src[7];
                  status_register[`CTB_STATUS_REGISTER_Z] <= ({src[6:0], w[12] & status_register[`CTB_STATUS_REGISTER_C]} == 8'h00);
                  status_register[`CTB_STATUS_REGISTER_N] <= src[6];
                  status_register[`CTB_STATUS_REGISTER_V] <= src[6] ^ src[7];
               end else if (is_nib_swap) begin
                  rf[rd] <= {src[3:0], src[7:4]};
               end else if (is_flag_bit) begin
                  status_register[w[6:4]] <= !w[7];
               end else if (w[15:9] == 7'b1111101 && !w[3]) begin
                  status_register[`CTB_STATUS_REGISTER_T] <= src[w[2:0]];
               end else if (w[15:9] == 7'b1111100 && !w[3]) begin
                  rf[rd][w[2:0]] <= status_register[`CTB_STATUS_REGISTER_T];
               end else if (w == 16'h9598) begin
                  debug_halt <= 1'b1;
               end else if (is_pgm_rd) begin
                  pmem <= '{req: 1'b1, we: 1'b0, addr: pair(5'h1E), wdata: 16'h0000};
                  pend_rd <= (w == 16'h95C8) ? 5'h00 : rd;
                  if (w[15:9] == 7'b1001000 && w[0]) begin
                     {rf[31], rf[30]} <= pair(5'h1E) + 16'h0001;
                  end
                  state <= ctb_pkg::CTB_ST_PGM1;
               end else if (w == 16'h95E8) begin
                  pmem <= '{req: 1'b1, we: 1'b1, addr: pair(5'h1E), wdata: pair(5'h00)};
                  state <= ctb_pkg::CTB_ST_PGM2;
               end else if (is_stack) begin
                  sp <= w[9] ? sp - 16'h0001 : sp + 16'h0001;
                  dmem <= '{req: 1'b1, we: w[9], addr: w[9] ? sp : sp + 16'h0001, wdata: src};
                  pend_rd <= rd;
                  pend_kind <= 2'b01;
                  state <= ctb_pkg::CTB_ST_MEM;
               end else if (is_abs_mem) begin
                  dmem <= '{req: 1'b1, we: w[9], addr: 16'h0000, wdata: src};
                  pend_rd <= rd;
                  pend_kind <= 2'b10;
                  state <= ctb_pkg::CTB_ST_MEM;
               end else if (is_ptr_mem) begin
                  // post-increment uses old value, pre-decrement the new one
                  dmem <= '{req: 1'b1, we: w[9], addr: w[1] ? ptr_dec : ptr, wdata: src};
                  if (w[1:0] == 2'b01) {rf[pidx + 5'h01], rf[pidx]} <= ptr_inc;
                  if (w[1:0] == 2'b10) {rf[pidx + 5'h01], rf[pidx]} <= ptr_dec;
                  pend_rd <= rd;
                  pend_kind <= 2'b01;
                  state <= ctb_pkg::CTB_ST_MEM;
               end else if (is_disp_mem) begin
                  dmem <= '{req: 1'b1, we: w[9], addr: (w[3] ? pair(5'h1C) : pair(5'h1E)) + {10'h000, q},
                            wdata: src};
                  pend_rd <= rd;
                  pend_kind <= 2'b01;
                  state <= ctb_pkg::CTB_ST_MEM;
               end
               // anything else, including the all-zero word, idles one cycle
            end
            ctb_pkg::CTB_ST_MEM: begin
               if (pend_kind == 2'b10) begin
                  // absolute form: address arrives as second bus word
                  if (issue_word2()) begin
                     dmem <= '{req: 1'b1, we: ir[9], addr: w, wdata: rf[pend_rd]};
                     pend_kind <= 2'b01;
                  end
               end else begin
                  if (pend_kind == 2'b11) begin
                     dmem <= '{req: 1'b1, we: 1'b1, addr: dmem.addr,
                               wdata: ir[9] ? (dmem_rdata | bit_mask(ir[2:0]))
                                            : (dmem_rdata & ~bit_mask(ir[2:0]))};
                  end else if (!ir[9] || ir[15:11] == 5'b10110) begin
                     rf[pend_rd] <= dmem_rdata;
                  end
                  state <= ctb_pkg::CTB_ST_IDLE;
               end
            end
            ctb_pkg::CTB_ST_PGM1: begin
               pmem.req <= 1'b0;
               state <= ctb_pkg::CTB_ST_PGM2;
            end
            ctb_pkg::CTB_ST_PGM2: begin
               pmem.req <= 1'b0;
               if (!pmem.we) begin
                  rf[pend_rd] <= pmem_rdata;
                  state <= ctb_pkg::CTB_ST_IDLE;
               end else if (pmem_done) begin
                  state <= ctb_pkg::CTB_ST_IDLE;
               end
            end
         endcase
      end
   end
   function automatic logic issue_word2();
      issue_word2 = ap_wr && ap_addr == `CTB_ADDR_INSTR;
   endfunction
endmodule

// *** ctb_defs.svh ***
`ifndef CTB_DEFS_SVH
`define CTB_DEFS_SVH
`define CTB_ADDR_INSTR   32'h0000_0000
`define CTB_ADDR_STATUS  32'h0000_0004
`define CTB_ADDR_REGSEL  32'h0000_0008
`define CTB_ADDR_REGDAT  32'h0000_000C
`define CTB_ADDR_PTRS    32'h0000_0010
`define CTB_ADDR_BUSY    32'h0000_0014
`define CTB_STATUS_REGISTER_C       3'h0
`define CTB_STATUS_REGISTER_Z       3'h1
`define CTB_STATUS_REGISTER_N       3'h2
`define CTB_STATUS_REGISTER_V       3'h3
`define CTB_STATUS_REGISTER_S       3'h4
`define CTB_STATUS_REGISTER_H       3'h5
`define CTB_STATUS_REGISTER_T       3'h6
`define CTB_STATUS_REGISTER_I       3'h7
`define CTB_STATUS_REGISTER_RESET   8'h00
`define CTB_SP_RESET     16'h10FF
`define CTB_IO_BASE      16'h0020
`endif

// *** ctb_pkg.sv ***
package ctb_pkg;
   typedef enum logic [1:0] {
      CTB_ST_IDLE = 2'b00,
      CTB_ST_MEM  = 2'b01,
      CTB_ST_PGM1 = 2'b10,
      CTB_ST_PGM2 = 2'b11
   } ctb_state_t;
   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ctb_mem_req_t;
   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ctb_pgm_req_t;
endpackage

// *** ctb_core_checker.sv ***
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module ctb_core_checker (
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  hsel,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic                  hready,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire ctb_pkg::ctb_mem_req_t dmem,
   input wire ctb_pkg::ctb_pgm_req_t pmem,
   input wire logic                  debug_halt
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_read;
      hsel && htrans[1] && !hwrite && hready;
   endsequence
   sequence s_load;
      dmem.req && !dmem.we;
   endsequence
   AST_HRESP_OKAY:
      assert property (hresp == 1'b0) else $error("hresp not okay");
   AST_READ_NOWAIT:
      assert property (s_read |=> hreadyout) else $error("read data phase stalled");
   // a stall only waits for the running instruction, never forever
   AST_STALL_BOUND:
      assert property ($fell(hreadyout) |-> ##[1:16] hreadyout) else $error("stall too long");
   AST_LOAD_SINGLE:
      assert property (s_load |=> !(dmem.req && !dmem.we)) else $error("second data read");
   AST_PMEM_SINGLE:
      assert property (pmem.req |=> !pmem.req) else $error("pmem request not a pulse");
   AST_HALT_PULSE:
      assert property (debug_halt |=> !debug_halt) else $error("halt not a pulse");
   AST_HALT_QUIET:
      assert property (debug_halt |-> !dmem.req && !pmem.req) else $error("halt touched memory");
   AST_MEM_EXCL:
      assert property (dmem.req |-> !pmem.req) else $error("both memories requested");
endmodule

// *** ctb_mem_model.sv ***
`timescale 1ns/1ps
// ------------------------------
// data and program memory
// ------------------------------
module ctb_mem_model (
   input  wire logic                  hclk,
   input  wire ctb_pkg::ctb_mem_req_t dmem,
   output logic [7:0]                 dmem_rdata,
   input  wire ctb_pkg::ctb_pgm_req_t pmem,
   output logic [7:0]                 pmem_rdata,
   output logic                       pmem_done
);
   logic [7:0] dm [0:255];
   logic [7:0] dq = 8'h00;
   logic [2:0] dn = 3'h0;
   initial begin
      pmem_rdata = 8'h00;
      pmem_done = 1'b0;
   end
   // outside a read the lines invert, so stale data never looks valid
   assign dmem_rdata = (dmem.req && !dmem.we) ? dm[dmem.addr[7:0]] : ~dq;
   always @(posedge hclk) begin
      if (dmem.req && dmem.we) dm[dmem.addr[7:0]] <= dmem.wdata;
      dq <= dmem_rdata;
      pmem_rdata <= pmem.req ? (pmem.addr[7:0] ^ 8'h5A) : ~pmem_rdata;
      dn <= (pmem.req && pmem.we) ? 3'h3 : ((dn != 3'h0) ? dn - 3'h1 : 3'h0);
      pmem_done <= (dn == 3'h1);
   end
endmodule

// *** cpu_transfer_and_bit_ops_test.sv ***
`timescale 1ns/1ps
`include "ctb_defs.svh"
// ------------------------------
// bench
// ------------------------------
module cpu_transfer_and_bit_ops_test;
   logic                  hclk;
   logic                  hresetn;
   logic                  hsel;
   logic [31:0]           haddr;
   logic [1:0]            htrans;
   logic                  hwrite;
   logic [2:0]            hsize;
   logic [31:0]           hwdata;
   logic [31:0]           hrdata;
   logic                  hreadyout;
   logic                  hresp;
   ctb_pkg::ctb_mem_req_t dmem;
   ctb_pkg::ctb_pgm_req_t pmem;
   logic [7:0]            dmem_rdata;
   logic [7:0]            pmem_rdata;
   logic                  pmem_done;
   logic                  debug_halt;
   logic                  dp_rd = 1'b0;
   logic [31:0]           lf = 32'h2467;
   logic [31:0]           eq[$];
   int                    n_fail = 0;
   int                    n_checks = 0;
   int                    n_halt = 0;
   logic [7:0]            v;
   logic [7:0]            e;
   logic [7:0]            sr = 8'h00;
   logic [15:0]           z;
   logic                  c;
   logic [15:0]           ops[5] = '{16'h0F00, 16'h9506, 16'h1F00, 16'h9507, 16'h9505};
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   ctb_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .dmem(dmem), .dmem_rdata(dmem_rdata), .pmem(pmem), .pmem_rdata(pmem_rdata), .pmem_done(pmem_done),
      .debug_halt(debug_halt));
   ctb_mem_model i_mem (.hclk(hclk), .dmem(dmem), .dmem_rdata(dmem_rdata), .pmem(pmem), .pmem_rdata(pmem_rdata),
      .pmem_done(pmem_done));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // d is the register index minus 16
   function automatic logic [15:0] immediate_load(input logic [3:0] d, input logic [7:0] k);
      return {4'hE, k[7:4], d, k[3:0]};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      if (w) hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic x(input logic [15:0] w);
      bus(`CTB_ADDR_INSTR, 1'b1, {16'h0000, w});
   endtask
   // the idle word stalls until the core is done, so the read sees final state
   task automatic rq(input logic [31:0] a, input logic [31:0] d);
      x(16'h0000);
      eq.push_back(d);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic cr(input logic [4:0] r, input logic [7:0] d);
      bus(`CTB_ADDR_REGSEL, 1'b1, {27'h0, r});
      rq(`CTB_ADDR_REGDAT, {24'h0, d});
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge hclk) begin
      if (dp_rd && hreadyout) check("hrdata", hrdata, eq.pop_front());
      if (pmem.req && pmem.we) check("pmem write", {pmem.addr, pmem.wdata}, eq.pop_front());
      dp_rd <= hsel && htrans[1] && !hwrite && hreadyout;
      if (debug_halt) n_halt++;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rq(`CTB_ADDR_STATUS, {24'h0, `CTB_STATUS_REGISTER_RESET});
      rq(`CTB_ADDR_PTRS, {`CTB_SP_RESET, 16'h0000});
      lf = nxt(lf);
      v = lf[7:0];
      x(immediate_load(4'h0, v));
      x(16'h2F20);
      cr(5'd18, v);
      x(16'h9502);
      cr(5'd16, {v[3:0], v[7:4]});
      rq(`CTB_ADDR_STATUS, {24'h0, sr});
      $display("moves done");
      for (int k = 0; k < 16; k++) begin
         x({8'h94, k[3], k[2:0], 4'h8});
         sr[k[2:0]] = !k[3];
         rq(`CTB_ADDR_STATUS, {24'h0, sr});
      end
      $display("flags done");
      for (int i = 0; i < 5; i++) begin
         lf = nxt(lf);
         v = lf[7:0];
         c = lf[8];
         x(immediate_load(4'h0, v));
         x(c ? 16'h9408 : 16'h9488);
         x(ops[i]);
         case (i)
            0: {c, e} = {v, 1'b0};
            1: {e, c} = {1'b0, v};
            2: {c, e} = {v, c};
            3: {e, c} = {c, v};
            default: {e, c} = {v[7], v};
         endcase
         sr = {3'b000, c, e[7] ^ c, e[7], e == 8'h00, c};
         cr(5'd16, e);
         rq(`CTB_ADDR_STATUS, {24'h0, sr});
      end
      $display("shifts done");
      lf = nxt(lf);
      v = lf[7:0];
      x(immediate_load(4'h0, v));
      x(immediate_load(4'h1, 8'h00));
      x(16'hFB03);
      x(16'hF915);
      sr[6] = v[3];
      rq(`CTB_ADDR_STATUS, {24'h0, sr});
      cr(5'd17, {2'b00, v[3], 5'b00000});
      z = {8'h01, lf[15:10], 2'b00};
      x(immediate_load(4'hE, z[7:0]));
      x(immediate_load(4'hF, z[15:8]));
      x(16'h9301);
      rq(`CTB_ADDR_PTRS, {`CTB_SP_RESET, z + 16'h1});
      x(16'h9112);
      cr(5'd17, v);
      rq(`CTB_ADDR_PTRS, {`CTB_SP_RESET, z});
      x(16'h9121);
      cr(5'd18, v);
      x(16'h8302);
      x(16'h8152);
      cr(5'd21, v);
      rq(`CTB_ADDR_PTRS, {`CTB_SP_RESET, z + 16'h1});
      x(16'h9130);
      x(z + 16'h3);
      cr(5'd19, v);
      x(16'h9300);
      x(16'h0040);
      x(16'h9140);
      x(16'h0040);
      cr(5'd20, v);
      x(16'h930F);
      rq(`CTB_ADDR_PTRS, {16'h10FE, z + 16'h1});
      x(16'h916F);
      cr(5'd22, v);
      $display("data memory done");
      x(16'hB905);
      x(16'h9A29);
      x(16'h982E);
      x(16'h9170);
      x(16'h0025);
      cr(5'd23, (v | 8'h02) & 8'hBF);
      x(16'hB195);
      cr(5'd25, (v | 8'h02) & 8'hBF);
      x(16'h9185);
      cr(5'd24, (z[7:0] + 8'h01) ^ 8'h5A);
      rq(`CTB_ADDR_PTRS, {`CTB_SP_RESET, z + 16'h2});
      x(16'h0108);
      eq.push_back({z + 16'h2, v, v});
      x(16'h95E8);
      x(16'h9598);
      x(16'h95A8);
      check("halt pulses", n_halt, 32'd1);
      rq(`CTB_ADDR_STATUS, {24'h0, sr});
      $display("program memory done");
      report_and_stop();
   end
endmodule
bind ctb_core ctb_core_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .dmem(dmem), .pmem(pmem), .debug_halt(debug_halt));
